// ==== core/dcs_pkg.sv ====
package dcs_pkg;

  // default sizes
  localparam int NCH      = 6;
  localparam int AW       = 16;
  localparam int DW       = 16;
  localparam int FW       = 8;
  localparam int SW       = 4;
  localparam int RAW      = 8;

  // register map: per-channel block at channel * stride, globals above
  localparam int          CH_STRIDE_LOG = 3;
  localparam logic [2:0]  REG_SRC       = 3'h0;
  localparam logic [2:0]  REG_DST       = 3'h1;
  localparam logic [2:0]  REG_CNT       = 3'h2;
  localparam logic [2:0]  REG_SFC       = 3'h3;
  localparam logic [2:0]  REG_MODE      = 3'h4;
  localparam logic [7:0]  GLB_BASE      = 8'h30;
  localparam logic [7:0]  REG_GSRC      = 8'h30;
  localparam logic [7:0]  REG_GDST      = 8'h31;
  localparam logic [7:0]  REG_GCNT      = 8'h32;
  localparam logic [7:0]  REG_GFRM      = 8'h33;
  localparam logic [7:0]  REG_ESTEPA    = 8'h34;
  localparam logic [7:0]  REG_ESTEPB    = 8'h35;
  localparam logic [7:0]  REG_FSTEPA    = 8'h36;
  localparam logic [7:0]  REG_FSTEPB    = 8'h37;
  localparam logic [7:0]  REG_PRIO      = 8'h38;
  localparam logic [7:0]  REG_ENABLE    = 8'h39;
  localparam logic [7:0]  REG_DONE      = 8'h3a;
  localparam logic [7:0]  REG_STATUS    = 8'h3b;

  // channel mode control fields
  localparam int MC_AUTO     = 15;
  localparam int MC_DWORD    = 14;
  localparam int MC_SMODE_HI = 13;
  localparam int MC_SMODE_LO = 12;
  localparam int MC_SOFF     = 11;
  localparam int MC_SSEL     = 10;
  localparam int MC_DOFF     = 5;
  localparam int MC_DSEL     = 4;
  localparam int MC_DMODE_HI = 3;
  localparam int MC_DMODE_LO = 2;

  // sync and frame control fields
  localparam int SFC_SYNC_HI = 15;
  localparam int SFC_SYNC_LO = 12;
  localparam int SFC_FRM_HI  = 7;
  localparam int SFC_FRM_LO  = 0;

  // status register fields
  localparam int ST_BUSY     = 15;

  // reset values
  localparam logic [DW-1:0] RST_WORD  = 16'h0000;
  localparam logic [FW-1:0] RST_FRAME = 8'h00;
  localparam logic [SW-1:0] SYNC_NONE = 4'h0;

  typedef enum logic [1:0] {
    AM_HOLD = 2'b00,
    AM_INC  = 2'b01,
    AM_DEC  = 2'b10,
    AM_IDX  = 2'b11
  } dcs_amode_t;

  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_READ = 2'b01,
    SQ_WRIT = 2'b10
  } dcs_seq_t;

  // one access on the memory / peripheral bus
  typedef struct packed {
    logic          req;
    logic          we;
    logic          ext;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } dcs_mem_req_t;

endpackage

// ==== core/dcs_dma_channel_sequencer.sv ====
`timescale 1ns/100ps
// Notes on behaviour
// - each channel has its own high/low priority bit; high channels served first
// - channels of equal priority are granted in rotating round-robin order
// - source and destination addresses update separately: hold, inc, dec or indexed
// - auto-reload restarts a finished block from global source, dest and count reloads
// - reloading only reads the global reload values, never clears them
// - frame counter is 8 bits, value zero means a single-frame block
// - frame counter decrements on the final read of a frame only
// - after the final frame with auto-reload, frame counter reloads from global frame reload
// - element counter is 16 bits and decrements after each element read
// - element count holds elements minus one; all ones gives 65536 elements
// - after the final frame with auto-reload, element counter reloads from global count
// - double-word element is two 16-bit accesses, addresses update after each half
// - double-word only when both source and destination are on-chip
// - source and destination select fields pick step pair a or b
// - element step is added on every access except the frame's last
// - frame step replaces element step on the final access of each frame
// - mode bit 5 makes destination off-chip, bit 11 source; zero keeps on-chip
// - 4-bit sync select picks the pacing event; zero runs unsynchronised
// - dma wins over the cpu for on-chip resources
module dcs_dma_channel_sequencer #(
  parameter int NCH = dcs_pkg::NCH
) (
  input  wire logic                              ref_clk,
  input  wire logic                              arst_n,
  input  wire logic                              clkEn,
  input  wire logic [dcs_pkg::RAW-1:0]           regAddr,
  input  wire logic [dcs_pkg::DW-1:0]            regWdata,
  input  wire logic                              regWr,
  input  wire logic                              regRd,
  output logic      [dcs_pkg::DW-1:0]            regRdata,
  input  wire logic [(1<<dcs_pkg::SW)-1:0]       syncEvt,
  output dcs_pkg::dcs_mem_req_t                  memReq,
  input  wire logic                              memAck,
  input  wire logic [dcs_pkg::DW-1:0]            memRdata,
  output logic                                   dmaOnChipClaim,
  output logic      [NCH-1:0]                    blockDone,
  output logic                                   busy
);

  localparam int CW = (NCH > 1) ? $clog2(NCH) : 1;

  typedef struct packed {
    logic [NCH-1:0][dcs_pkg::AW-1:0] srcPtr;
    logic [NCH-1:0][dcs_pkg::AW-1:0] dstPtr;
    logic [NCH-1:0][dcs_pkg::DW-1:0] elemCnt;
    logic [NCH-1:0][dcs_pkg::DW-1:0] elemInit;
    logic [NCH-1:0][dcs_pkg::DW-1:0] modeCtl;
    logic [NCH-1:0][dcs_pkg::SW-1:0] syncSel;
    logic [NCH-1:0][dcs_pkg::FW-1:0] frameCnt;
    logic [dcs_pkg::AW-1:0]          gSrc;
    logic [dcs_pkg::AW-1:0]          gDst;
    logic [dcs_pkg::DW-1:0]          gCnt;
    logic [dcs_pkg::FW-1:0]          gFrm;
    logic [dcs_pkg::DW-1:0]          stepA;
    logic [dcs_pkg::DW-1:0]          stepB;
    logic [dcs_pkg::DW-1:0]          fstepA;
    logic [dcs_pkg::DW-1:0]          fstepB;
    logic [NCH-1:0]                  prioHigh;
    logic [NCH-1:0]                  chanEn;
    logic [NCH-1:0]                  done;
    logic [NCH-1:0]                  syncPend;
    logic [CW-1:0]                   lastHi;
    logic [CW-1:0]                   lastLo;
    logic [CW-1:0]                   act;
    dcs_pkg::dcs_seq_t               seq;
    logic                            half;
    logic                            lastAcc;
    logic                            blockEnd;
    logic [dcs_pkg::DW-1:0]          data;
    dcs_pkg::dcs_mem_req_t           mem;
    logic                            claim;
    logic                            busyFlag;
    logic [dcs_pkg::DW-1:0]          rdData;
  } dcs_state_t;

  dcs_state_t st;
  dcs_state_t next_st;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // first ready channel after the last one served, wrapping around
  function automatic logic [CW:0] pickNext(input logic [NCH-1:0] rdy, input logic [CW-1:0] last);
    logic [CW:0] res;
    int          j;
    res = '0;
    for (int i = NCH; i >= 1; i--) begin
      j = (int'(last) + i) % NCH;
      if (rdy[j]) begin
        res = {1'b1, CW'(j)};
      end
    end
    return res;
  endfunction

  // post-access address update
  function automatic logic [dcs_pkg::AW-1:0] stepAddr(input logic [dcs_pkg::AW-1:0] addr,
                                                     input logic [1:0] mode,
                                                     input logic [dcs_pkg::DW-1:0] step);
    logic [dcs_pkg::AW-1:0] res;
    res = addr;
    unique case (dcs_pkg::dcs_amode_t'(mode))
      dcs_pkg::AM_HOLD: res = addr;
      dcs_pkg::AM_INC:  res = addr + 16'h0001;
      dcs_pkg::AM_DEC:  res = addr - 16'h0001;
      dcs_pkg::AM_IDX:  res = addr + step;
    endcase
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decoded views of the current channel

  logic [NCH-1:0]         ready;
  logic [CW:0]            pickHi;
  logic [CW:0]            pickLo;
  logic [dcs_pkg::DW-1:0] mc;
  logic                   dwEff;
  logic [dcs_pkg::DW-1:0] srcStep;
  logic [dcs_pkg::DW-1:0] dstStep;
  logic                   elemLast;
  logic                   chHit;
  logic [CW-1:0]          chIdx;
  logic [2:0]             chReg;

  // channel ready: enabled and either free-running or an event pending
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      ready[c] = st.chanEn[c] & ((st.syncSel[c] == dcs_pkg::SYNC_NONE) | st.syncPend[c]);
    end
  end

  // separate rotations for the two priority levels
  assign pickHi = pickNext(ready & st.prioHigh, st.lastHi);
  assign pickLo = pickNext(ready & ~st.prioHigh, st.lastLo);

  assign mc       = st.modeCtl[st.act];
  assign dwEff    = mc[dcs_pkg::MC_DWORD] & ~mc[dcs_pkg::MC_SOFF] & ~mc[dcs_pkg::MC_DOFF];
  assign elemLast = (st.elemCnt[st.act] == dcs_pkg::RST_WORD) & (~dwEff | st.half);

  // step pair selection and frame-end substitution
  always_comb begin
    if (elemLast) begin
      srcStep = mc[dcs_pkg::MC_SSEL] ? st.fstepB : st.fstepA;
    end else begin
      srcStep = mc[dcs_pkg::MC_SSEL] ? st.stepB : st.stepA;
    end
    if (st.lastAcc) begin
      dstStep = mc[dcs_pkg::MC_DSEL] ? st.fstepB : st.fstepA;
    end else begin
      dstStep = mc[dcs_pkg::MC_DSEL] ? st.stepB : st.stepA;
    end
  end

  assign chHit = (regAddr < dcs_pkg::GLB_BASE) &&
                 (int'(regAddr[dcs_pkg::RAW-1:dcs_pkg::CH_STRIDE_LOG]) < NCH);
  assign chIdx = CW'(regAddr[dcs_pkg::RAW-1:dcs_pkg::CH_STRIDE_LOG]);
  assign chReg = regAddr[dcs_pkg::CH_STRIDE_LOG-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [NCH-1:0] doneSet;
    logic [NCH-1:0] grant;
    logic           evt;
    logic [CW-1:0]  a;
    next_st = st;
    doneSet = '0;
    grant   = '0;
    evt     = 1'b0;
    a       = st.act;
    next_st.rdData = dcs_pkg::RST_WORD;

    // sequencer
    unique case (st.seq)
      dcs_pkg::SQ_IDLE: begin
        if (pickHi[CW] | pickLo[CW]) begin
          a = pickHi[CW] ? pickHi[CW-1:0] : pickLo[CW-1:0];
          if (pickHi[CW]) begin
            next_st.lastHi = a;
          end else begin
            next_st.lastLo = a;
          end
          grant[a]          = 1'b1;
          next_st.act       = a;
          next_st.half      = 1'b0;
          next_st.seq       = dcs_pkg::SQ_READ;
          next_st.mem.req   = 1'b1;
          next_st.mem.we    = 1'b0;
          next_st.mem.ext   = st.modeCtl[a][dcs_pkg::MC_SOFF];
          next_st.mem.addr  = st.srcPtr[a];
          next_st.claim     = ~st.modeCtl[a][dcs_pkg::MC_SOFF];
        end
      end
      dcs_pkg::SQ_READ: begin
        if (memAck) begin
          next_st.data      = memRdata;
          next_st.lastAcc   = elemLast;
          next_st.blockEnd  = elemLast & (st.frameCnt[a] == dcs_pkg::RST_FRAME);
          next_st.srcPtr[a] = stepAddr(st.srcPtr[a], mc[dcs_pkg::MC_SMODE_HI:dcs_pkg::MC_SMODE_LO],
                                       srcStep);
          if (~dwEff | st.half) begin
            if (st.elemCnt[a] == dcs_pkg::RST_WORD) begin
              if (st.frameCnt[a] != dcs_pkg::RST_FRAME) begin
                next_st.frameCnt[a] = st.frameCnt[a] - 8'h01;
                next_st.elemCnt[a]  = st.elemInit[a];
              end
            end else begin
              next_st.elemCnt[a] = st.elemCnt[a] - 16'h0001;
            end
          end
          next_st.seq       = dcs_pkg::SQ_WRIT;
          next_st.mem.we    = 1'b1;
          next_st.mem.ext   = mc[dcs_pkg::MC_DOFF];
          next_st.mem.addr  = st.dstPtr[a];
          next_st.mem.wdata = memRdata;
          next_st.claim     = ~mc[dcs_pkg::MC_DOFF];
        end
      end
      dcs_pkg::SQ_WRIT: begin
        if (memAck) begin
          next_st.dstPtr[a] = stepAddr(st.dstPtr[a], mc[dcs_pkg::MC_DMODE_HI:dcs_pkg::MC_DMODE_LO],
                                       dstStep);
          if (dwEff & ~st.half) begin
            // second half of a double word, same element
            next_st.half     = 1'b1;
            next_st.seq      = dcs_pkg::SQ_READ;
            next_st.mem.we   = 1'b0;
            next_st.mem.ext  = 1'b0;
            next_st.mem.addr = st.srcPtr[a];
            next_st.claim    = 1'b1;
          end else begin
            next_st.seq       = dcs_pkg::SQ_IDLE;
            next_st.mem.req   = 1'b0;
            next_st.mem.we    = 1'b0;
            next_st.claim     = 1'b0;
            if (st.blockEnd) begin
              doneSet[a] = 1'b1;
              if (mc[dcs_pkg::MC_AUTO]) begin
                // globals are only read here, so one load serves every block
                next_st.srcPtr[a]   = st.gSrc;
                next_st.dstPtr[a]   = st.gDst;
                next_st.elemCnt[a]  = st.gCnt;
                next_st.elemInit[a] = st.gCnt;
                next_st.frameCnt[a] = st.gFrm;
              end else begin
                next_st.chanEn[a] = 1'b0;
              end
            end
          end
        end
      end
      default: begin
        next_st.seq     = dcs_pkg::SQ_IDLE;
        next_st.mem.req = 1'b0;
        next_st.claim   = 1'b0;
      end
    endcase

    // sync event latch, a new event beats the clear from a grant
    for (int c = 0; c < NCH; c++) begin
      evt = (st.syncSel[c] != dcs_pkg::SYNC_NONE) & syncEvt[st.syncSel[c]];
      next_st.syncPend[c] = (st.syncPend[c] & ~grant[c]) | evt;
    end

    // register writes
    if (regWr) begin
      if (chHit) begin
        unique case (chReg)
          dcs_pkg::REG_SRC:  next_st.srcPtr[chIdx] = regWdata;
          dcs_pkg::REG_DST:  next_st.dstPtr[chIdx] = regWdata;
          dcs_pkg::REG_CNT: begin
            next_st.elemCnt[chIdx]  = regWdata;
            next_st.elemInit[chIdx] = regWdata;
          end
          dcs_pkg::REG_SFC: begin
            next_st.syncSel[chIdx]  = regWdata[dcs_pkg::SFC_SYNC_HI:dcs_pkg::SFC_SYNC_LO];
            next_st.frameCnt[chIdx] = regWdata[dcs_pkg::SFC_FRM_HI:dcs_pkg::SFC_FRM_LO];
          end
          dcs_pkg::REG_MODE: next_st.modeCtl[chIdx] = regWdata;
          default: ;
        endcase
      end else begin
        unique case (regAddr)
          dcs_pkg::REG_GSRC:   next_st.gSrc     = regWdata;
          dcs_pkg::REG_GDST:   next_st.gDst     = regWdata;
          dcs_pkg::REG_GCNT:   next_st.gCnt     = regWdata;
          dcs_pkg::REG_GFRM:   next_st.gFrm     = regWdata[dcs_pkg::FW-1:0];
          dcs_pkg::REG_ESTEPA: next_st.stepA    = regWdata;
          dcs_pkg::REG_ESTEPB: next_st.stepB    = regWdata;
          dcs_pkg::REG_FSTEPA: next_st.fstepA   = regWdata;
          dcs_pkg::REG_FSTEPB: next_st.fstepB   = regWdata;
          dcs_pkg::REG_PRIO:   next_st.prioHigh = regWdata[NCH-1:0];
          dcs_pkg::REG_ENABLE: next_st.chanEn   = regWdata[NCH-1:0];
          dcs_pkg::REG_DONE:   next_st.done     = st.done & ~regWdata[NCH-1:0];
          default: ;
        endcase
      end
    end
    // completion set wins over a same-cycle clear
    next_st.done = next_st.done | doneSet;
    // busy registered beside the sequencer so the pin comes from a flop
    next_st.busyFlag = (next_st.seq != dcs_pkg::SQ_IDLE);

    // register reads, data valid the following cycle
    if (regRd) begin
      if (chHit) begin
        unique case (chReg)
          dcs_pkg::REG_SRC:  next_st.rdData = st.srcPtr[chIdx];
          dcs_pkg::REG_DST:  next_st.rdData = st.dstPtr[chIdx];
          dcs_pkg::REG_CNT:  next_st.rdData = st.elemCnt[chIdx];
          dcs_pkg::REG_SFC: begin
            next_st.rdData[dcs_pkg::SFC_SYNC_HI:dcs_pkg::SFC_SYNC_LO] = st.syncSel[chIdx];
            next_st.rdData[dcs_pkg::SFC_FRM_HI:dcs_pkg::SFC_FRM_LO]   = st.frameCnt[chIdx];
          end
          dcs_pkg::REG_MODE: next_st.rdData = st.modeCtl[chIdx];
          default: ;
        endcase
      end else begin
        unique case (regAddr)
          dcs_pkg::REG_GSRC:   next_st.rdData = st.gSrc;
          dcs_pkg::REG_GDST:   next_st.rdData = st.gDst;
          dcs_pkg::REG_GCNT:   next_st.rdData = st.gCnt;
          dcs_pkg::REG_GFRM:   next_st.rdData[dcs_pkg::FW-1:0] = st.gFrm;
          dcs_pkg::REG_ESTEPA: next_st.rdData = st.stepA;
          dcs_pkg::REG_ESTEPB: next_st.rdData = st.stepB;
          dcs_pkg::REG_FSTEPA: next_st.rdData = st.fstepA;
          dcs_pkg::REG_FSTEPB: next_st.rdData = st.fstepB;
          dcs_pkg::REG_PRIO:   next_st.rdData[NCH-1:0] = st.prioHigh;
          dcs_pkg::REG_ENABLE: next_st.rdData[NCH-1:0] = st.chanEn;
          dcs_pkg::REG_DONE:   next_st.rdData[NCH-1:0] = st.done;
          dcs_pkg::REG_STATUS: begin
            next_st.rdData[dcs_pkg::ST_BUSY] = (st.seq != dcs_pkg::SQ_IDLE);
            next_st.rdData[CW-1:0]           = st.act;
          end
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register, frozen while clkEn is low

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all straight from the state register

  assign regRdata       = st.rdData;
  assign memReq         = st.mem;
  assign dmaOnChipClaim = st.claim;
  assign blockDone      = st.done;
  assign busy           = st.busyFlag;

endmodule

// ==== dv/dcs_seq_properties.sv ====
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
// port-level checks on the channel sequencer
module dcs_seq_properties #(
  parameter int NCH = dcs_pkg::NCH
) (
  input  wire logic                    ref_clk,
  input  wire logic                    arst_n,
  input  wire logic                    regWr,
  input  wire dcs_pkg::dcs_mem_req_t   memReq,
  input  wire logic                    memAck,
  input  wire logic [dcs_pkg::DW-1:0]  memRdata,
  input  wire logic                    dmaOnChipClaim,
  input  wire logic [NCH-1:0]          blockDone,
  input  wire logic                    busy
);
  logic wrAck;

  default clocking ck @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // completed write access
  assign wrAck = memReq.req & memReq.we & memAck;

  property p_claim; memReq.req |-> dmaOnChipClaim == !memReq.ext; endproperty
  a_claim: assert property (p_claim) else $error("claim disagrees with access locality");
  property p_noclaim; !memReq.req |-> !dmaOnChipClaim; endproperty
  a_noclaim: assert property (p_noclaim) else $error("claim without an access");
  property p_hold; memReq.req && !memAck |=> memReq.req && $stable(memReq); endproperty
  a_hold: assert property (p_hold) else $error("access changed before answer");
  property p_copy;
    memReq.req && !memReq.we && memAck |=> memReq.req && memReq.we && memReq.wdata == $past(memRdata);
  endproperty
  a_copy: assert property (p_copy) else $error("write does not carry read word");
  property p_after_wr; wrAck |=> !(memReq.req && memReq.we); endproperty
  a_after_wr: assert property (p_after_wr) else $error("write follows write");
  property p_busy; memReq.req |-> busy; endproperty
  a_busy: assert property (p_busy) else $error("access while not busy");
  property p_sticky; !$past(regWr) |-> (blockDone & $past(blockDone)) == $past(blockDone); endproperty
  a_sticky: assert property (p_sticky) else $error("done flag lost without a write");
  property p_cause; (blockDone & ~$past(blockDone)) != '0 |-> $past(wrAck) || $past(wrAck, 2); endproperty
  a_cause: assert property (p_cause) else $error("done flag without final write");
endmodule

bind dcs_dma_channel_sequencer dcs_seq_properties #(.NCH(NCH)) u_props (
  .ref_clk(ref_clk), .arst_n(arst_n), .regWr(regWr), .memReq(memReq), .memAck(memAck),
  .memRdata(memRdata), .dmaOnChipClaim(dmaOnChipClaim), .blockDone(blockDone), .busy(busy)
);

// ==== dv/dcs_mem_model.sv ====
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
// memory and peripheral space behind the channel
module dcs_mem_model (
  input  wire logic                  ref_clk,
  input  wire logic                  arst_n,
  input  wire dcs_pkg::dcs_mem_req_t memReq,
  input  wire logic [1:0]            slow,
  output logic                       memAck,
  output logic [15:0]                memRdata
);
  logic [15:0] mem [256];
  logic [15:0] lastData;
  logic [1:0]  waitCnt;
  int          extCnt = 0;
  logic [7:0]  rdLog [$];

  // answer once the chosen wait has run out
  assign memAck   = memReq.req && waitCnt == slow;
  assign memRdata = (memAck && !memReq.we) ? mem[memReq.addr[7:0]] : ~lastData; // idle bus shows inverse

  // count waits, store writes, log reads
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      waitCnt  <= 2'h0;
      lastData <= 16'h0000;
    end else if (memAck) begin
      waitCnt <= 2'h0;
      extCnt  <= extCnt + int'(memReq.ext);
      if (memReq.we) begin
        mem[memReq.addr[7:0]] <= memReq.wdata;
      end else begin
        lastData <= memRdata;
        rdLog.push_back(memReq.addr[7:0]);
      end
    end else if (memReq.req) begin
      waitCnt <= waitCnt + 2'h1;
    end
  end
endmodule

// ==== dv/dma_channel_sequencer_bench.sv ====
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
module dma_channel_sequencer_bench;
  // rows: source, dest, count, sync/frame, mode
  localparam logic [15:0] ROWS [6][5] = '{
    '{16'h0010, 16'h0080, 16'h0003, 16'h0000, 16'h1004},
    '{16'h002f, 16'h0088, 16'h0002, 16'h0001, 16'h200c},
    '{16'h0040, 16'h0098, 16'h0001, 16'h0000, 16'h3400},
    '{16'h0044, 16'h009c, 16'h0001, 16'h0000, 16'h5004},
    '{16'h0048, 16'h00c0, 16'h0001, 16'h0000, 16'h5024},
    '{16'h004c, 16'h00c8, 16'h0001, 16'h0000, 16'h5804}};
  localparam logic [15:0] ST [4] = '{16'h0002, 16'h0003, 16'h0005, 16'hfffd};
  logic                  ref_clk = 1'b0;
  logic                  arst_n = 1'b0;
  logic                  clkEn = 1'b1;
  logic [7:0]            regAddr = 8'h00;
  logic [15:0]           regWdata = 16'h0000;
  logic                  regWr = 1'b0;
  logic                  regRd = 1'b0;
  logic [15:0]           regRdata;
  logic [15:0]           syncEvt = 16'h0000;
  dcs_pkg::dcs_mem_req_t memReq;
  logic                  memAck;
  logic [15:0]           memRdata;
  logic                  dmaOnChipClaim;
  logic [5:0]            blockDone;
  logic                  busy;
  logic [1:0]            slow = 2'h0;
  logic [15:0]           shadow [256];
  logic [15:0]           s;
  logic [15:0]           d;
  int                    failures = 0;
  int                    total_checks = 0;
  int                    cycles = 0;
  int                    n0;

  dcs_dma_channel_sequencer dut (.ref_clk(ref_clk), .arst_n(arst_n), .clkEn(clkEn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .syncEvt(syncEvt),
    .memReq(memReq), .memAck(memAck), .memRdata(memRdata), .dmaOnChipClaim(dmaOnChipClaim),
    .blockDone(blockDone), .busy(busy));
  dcs_mem_model mdl (.ref_clk(ref_clk), .arst_n(arst_n), .memReq(memReq), .slow(slow),
    .memAck(memAck), .memRdata(memRdata));

  ////////////////////////////////////////////////////////////
  // clock and hang limit
  initial forever #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      results();
    end
  end

  task automatic results();
    if (failures == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= v;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 chk(regRdata, exp);
  endtask

  task automatic pulse();
    @(posedge ref_clk);
    syncEvt <= 16'h0020;
    @(posedge ref_clk);
    syncEvt <= 16'h0000;
  endtask

  task automatic wait_done(input int ch);
    for (int n = 0; n < 2000 && blockDone[ch] !== 1'b1; n++) @(posedge ref_clk);
    chk(16'(blockDone[ch]), 16'h0001);
  endtask

  // address step of one side for one access
  function automatic logic [15:0] stp(input logic [1:0] m, input logic sel, input logic last);
    case (m)
      2'b01: stp = 16'h0001;
      2'b10: stp = 16'hffff;
      2'b11: stp = ST[{last, sel}];
      default: stp = 16'h0000;
    endcase
  endfunction

  // replay one block on the shadow memory
  task automatic expect_row(input logic [15:0] m, n, f);
    int h;
    h = (m[14] && !m[5] && !m[11]) ? 2 : 1;
    for (int fr = 0; fr <= int'(f[7:0]); fr++)
      for (int e = 0; e <= int'(n); e++)
        for (int k = 0; k < h; k++) begin
          shadow[d[7:0]] = shadow[s[7:0]];
          s = s + stp(m[13:12], m[10], e == int'(n) && k == h - 1);
          d = d + stp(m[3:2], m[4], e == int'(n) && k == h - 1);
        end
  endtask

  ////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    for (int i = 0; i < 256; i++) begin
      mdl.mem[i] = 16'(i * 257) ^ 16'h5a3c;
      shadow[i]  = 16'(i * 257) ^ 16'h5a3c;
    end
    repeat (6) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    #1 chk(16'({busy, blockDone}), 16'h0000);
    rd(8'h04, 16'h0000);
    rd(8'h03, 16'h0000);
    rd(8'h3d, 16'h0000);
    for (int k = 0; k < 4; k++) wr(8'(52 + k), ST[k]);
    rd(8'h37, 16'hfffd);
    // a write while the clock enable is low must be dropped
    @(posedge ref_clk);
    clkEn <= 1'b0;
    wr(8'h37, 16'h0000);
    clkEn <= 1'b1;
    rd(8'h37, 16'hfffd);
    wr(8'h2a, 16'hffff);
    rd(8'h2a, 16'hffff);
    wr(8'h2b, 16'h00ff);
    rd(8'h2b, 16'h00ff);
    // ordinary blocks, one channel per row
    for (int r = 0; r < 6; r++) begin
      for (int k = 0; k < 5; k++) wr(8'(8 * r + k), ROWS[r][k]);
      s  = ROWS[r][0];
      d  = ROWS[r][1];
      expect_row(ROWS[r][4], ROWS[r][2], ROWS[r][3]);
      n0 = mdl.extCnt;
      wr(8'h39, 16'(1 << r));
      wait_done(r);
      for (int i = 0; i < 256; i++) chk(mdl.mem[i], shadow[i]);
      chk(16'(mdl.extCnt - n0), (ROWS[r][4][5] || ROWS[r][4][11]) ? 16'h0002 : 16'h0000);
      rd(8'(8 * r), s);
      rd(8'(8 * r + 1), d);
      rd(8'(8 * r + 2), 16'h0000);
      rd(8'(8 * r + 3), 16'h0000);
      rd(8'h39, 16'h0000);
      wr(8'h3a, 16'(1 << r));
      #1 chk(16'(blockDone[r]), 16'h0000);
    end
    // two high channels against one low, slow memory
    slow <= 2'h2;
    wr(8'h38, 16'h0006);
    for (int c = 0; c < 3; c++) begin
      wr(8'(8 * c), 16'(16'h0050 + 16 * c));
      wr(8'(8 * c + 1), 16'(16'h00d0 + 16 * c));
      wr(8'(8 * c + 2), (c == 0) ? 16'h0000 : 16'h0001);
      wr(8'(8 * c + 4), 16'h0000);
    end
    n0 = mdl.rdLog.size();
    wr(8'h39, 16'h0007);
    rd(8'h3b, 16'h8001);
    chk(16'(busy), 16'h0001);
    wait_done(0);
    chk(16'(mdl.rdLog[n0][7:5]), 16'h0003);
    chk(16'(mdl.rdLog[n0 + 1][7:5] == 3'h3 && mdl.rdLog[n0] != mdl.rdLog[n0 + 1]), 16'h0001);
    chk(16'(mdl.rdLog[n0 + 2]), 16'(mdl.rdLog[n0]));
    chk(16'(mdl.rdLog[n0 + 3]), 16'(mdl.rdLog[n0 + 1]));
    chk(16'(mdl.rdLog[n0 + 4]), 16'h0050);
    wr(8'h3a, 16'h0007);
    // paced auto-reload on channel 3
    slow <= 2'h0;
    wr(8'h30, 16'h0020);
    wr(8'h31, 16'h00a0);
    wr(8'h32, 16'h0000);
    wr(8'h33, 16'h0001);
    for (int k = 0; k < 5; k++) wr(8'(24 + k), (k == 0) ? 16'h0020 : (k == 1) ? 16'h00a0 :
      (k == 3) ? 16'h5000 : (k == 4) ? 16'h9004 : 16'h0000);
    n0 = mdl.rdLog.size();
    wr(8'h39, 16'h0008);
    repeat (10) @(posedge ref_clk);
    chk(16'(mdl.rdLog.size() - n0), 16'h0000);
    pulse();
    wait_done(3);
    wr(8'h3a, 16'h0008);
    rd(8'h18, 16'h0020);
    rd(8'h1a, 16'h0000);
    rd(8'h1b, 16'h5001);
    wr(8'h31, 16'h00b0);
    pulse();
    repeat (8) @(posedge ref_clk);
    pulse();
    wait_done(3);
    rd(8'h19, 16'h00b0);
    rd(8'h31, 16'h00b0);
    rd(8'h33, 16'h0001);
    chk(mdl.mem[8'ha1], shadow[8'h21]);
    wr(8'h39, 16'h0000);
    results();
  end
endmodule
